// >>> shg_guard.sv
// Functional notes
// - Keep read, write and lock flags for 32 host blocks, indexed registers.
// - Host block is translated core address bits 20..0 divided by 64K.
// - Protect write with index-write clear updates flags of indexed block.
// - Protect write with index-write set only selects block for reads.
// - Core read/write override per block; first two blocks split in 16.
// - Core sets and clears override bits through six override registers.
// - Access restricted when its type is protected for the core address.
// - Also restricted during core warm reset or when flash is empty.
// - Restricted access raises core interrupt when host-error enable set.
// - Restricted access sets host write error or host read error flag.
// - Restricted write discarded; error sync if field 10, else ready.
// - Restricted read with field 00 holds long wait until resolved.
// - Restricted read returns 00; ready sync on 01, error on 10.
// - One 8-bit signaling register readable by host and core.
// - Host alone modifies signaling bits 3..0, core alone bits 7..4.
// - Host signaling write sets written flag, interrupt if enabled.
// - Indirect 32-bit address from four byte registers at offsets 0..3.
// - Indirect data byte register at offset 4.
// - Host registers reachable by the host only.
// - Indirect data access runs a core bus write or read.
// - Address registers answer short wait; data waits long until done.
// - Set lock freezes that block's flags until host hardware reset.
// - Core override denies access even if host flags allow it.
`timescale 1ns/1ps
`include "shg_regs.svh"
module shg_guard (
  input  wire logic                   sys_clk,
  input  wire logic                   reset,
  input  wire logic                   host_req,
  input  wire logic                   host_io,
  input  wire logic                   host_wr,
  input  wire logic [31:0]            host_addr,
  input  wire logic [7:0]             host_wdata,
  output logic      [3:0]             host_sync_r,
  output logic                        host_done_r,
  output logic      [7:0]             host_rdata_r,
  input  wire logic                   core_wr,
  input  wire logic [2:0]             core_addr,
  input  wire logic [15:0]            core_wdata,
  output logic      [15:0]            core_rdata_r,
  output logic                        core_irq_r,
  input  wire logic [20:0]            main_block_top_address,
  input  wire logic                   core_warm_reset,
  input  wire logic [3:0]             boot_block_field,
  output logic                        mem_req_r,
  output logic                        mem_we_r,
  output logic      [20:0]            mem_addr_r,
  output logic      [7:0]             mem_wdata_r,
  input  wire logic [7:0]             mem_rdata,
  input  wire logic                   mem_done,
  output logic                        page_erase_r
);
  import shg_pkg::*;

  shg_state_type state_r;
  logic [31:0]   hrp_r;
  logic [31:0]   hwp_r;
  logic [31:0]   hlp_r;
  logic [3:0]    idx_lo_r;
  logic [3:0]    idx_hi_r;
  logic          iw_lo_r;
  logic          iw_hi_r;
  logic [47:0]   ovr_rd_r;
  logic [47:0]   ovr_wr_r;
  logic [31:0]   ind_addr_r;
  logic [7:0]    data_r;
  logic [7:0]    hctl_r;
  logic [7:0]    sem_r;
  logic          host_error_irq_enable_r;
  logic          semaphore_irq_enable_r;
  logic [1:0]    host_error_response_field_r;
  logic          host_write_error_flag_r;
  logic          host_read_error_flag_r;
  logic          host_semaphore_written_r;
  logic [20:0]   cur_addr_r;
  logic          cur_wr_r;

  logic [3:0]    io_off;
  logic          take;
  logic          io_take;
  logic          io_wr;
  logic          mem_take;
  logic [31:0]   req_addr;
  logic [20:0]   req_core;
  logic          req_restr;
  logic          hold_restr;
  logic [7:0]    io_rd_val;
  logic          ccst_wr;

  // Restriction check on a translated core address
  function automatic logic restricted(input logic [20:0] a, input logic wr,
                                      input logic [31:0] hrp, input logic [31:0] hwp,
                                      input logic [47:0] ord, input logic [47:0] owr,
                                      input logic warm, input logic [3:0] boot);
    logic [4:0] blk;
    logic [5:0] ob;
    blk = a[20:16];
    ob  = (a[20:17] == 4'h0) ? {2'b00, a[16:13]} : ({1'b0, a[20:16]} + `SHG_FINE_OFFSET);
    restricted = warm || (boot == `SHG_BOOT_EMPTY) ||
                 (wr ? (hwp[blk] || owr[ob]) : (hrp[blk] || ord[ob]));
  endfunction

  assign io_off   = host_addr[3:0];
  assign take     = host_req && (state_r == shg_idle);
  assign io_take  = take && host_io;
  assign io_wr    = io_take && host_wr;
  assign mem_take = take && (!host_io || io_off == `SHG_OFF_DATA);
  assign req_addr = host_io ? ind_addr_r : host_addr;
  assign req_core = req_addr[20:0] + main_block_top_address;
  assign req_restr = restricted(req_core, host_wr, hrp_r, hwp_r, ovr_rd_r, ovr_wr_r,
                                core_warm_reset, boot_block_field);
  assign hold_restr = restricted(cur_addr_r, 1'b0, hrp_r, hwp_r, ovr_rd_r, ovr_wr_r,
                                 core_warm_reset, boot_block_field);
  assign ccst_wr  = core_wr && (core_addr == `SHG_COFF_CCST);

  // Host register read view
  always_comb begin
    case (io_off)
      4'h0:             io_rd_val = ind_addr_r[7:0];
      4'h1:             io_rd_val = ind_addr_r[15:8];
      4'h2:             io_rd_val = ind_addr_r[23:16];
      `SHG_OFF_ADDR3:   io_rd_val = ind_addr_r[31:24];
      `SHG_OFF_HCTL:    io_rd_val = hctl_r;
      `SHG_OFF_PROT_LO: io_rd_val = {idx_lo_r, iw_lo_r, hlp_r[{1'b0, idx_lo_r}],
                                     hwp_r[{1'b0, idx_lo_r}], hrp_r[{1'b0, idx_lo_r}]};
      `SHG_OFF_PROT_HI: io_rd_val = {idx_hi_r, iw_hi_r, hlp_r[{1'b1, idx_hi_r}],
                                     hwp_r[{1'b1, idx_hi_r}], hrp_r[{1'b1, idx_hi_r}]};
      `SHG_OFF_SEM:     io_rd_val = sem_r;
      default:          io_rd_val = 8'h00;
    endcase
  end

  // Host-controlled protection flags, one set per block
  genvar g;
  generate
    for (g = 0; g < 32; g = g + 1) begin : g_blk
      logic sel;
      assign sel = io_wr && !host_wdata[3] && (host_wdata[7:4] == 4'(g % 16)) &&
                   (io_off == ((g < 16) ? `SHG_OFF_PROT_LO : `SHG_OFF_PROT_HI));
      always_ff @(posedge sys_clk) begin
        if (reset) begin
          hrp_r[g] <= 1'b0;
          hwp_r[g] <= 1'b1;
          hlp_r[g] <= 1'b0;
        end else if (sel && !hlp_r[g]) begin
          hrp_r[g] <= host_wdata[0];
          hwp_r[g] <= host_wdata[1];
          hlp_r[g] <= host_wdata[2];
        end
      end
    end
  endgenerate

  // Index fields; a protect write with index-write set only moves the index
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      idx_lo_r <= 4'h0;
      idx_hi_r <= 4'h0;
      iw_lo_r  <= 1'b0;
      iw_hi_r  <= 1'b0;
    end else if (io_wr && io_off == `SHG_OFF_PROT_LO) begin
      idx_lo_r <= host_wdata[7:4];
      iw_lo_r  <= host_wdata[3];
    end else if (io_wr && io_off == `SHG_OFF_PROT_HI) begin
      idx_hi_r <= host_wdata[7:4];
      iw_hi_r  <= host_wdata[3];
    end
  end

  // Indirect address and host control; host side only
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      ind_addr_r <= 32'h0000_0000;
      hctl_r     <= `SHG_HCTL_RST;
    end else if (io_wr) begin
      case (io_off)
        4'h0:           ind_addr_r[7:0]   <= host_wdata;
        4'h1:           ind_addr_r[15:8]  <= host_wdata;
        4'h2:           ind_addr_r[23:16] <= host_wdata;
        `SHG_OFF_ADDR3: ind_addr_r[31:24] <= host_wdata;
        `SHG_OFF_HCTL:  hctl_r <= host_wdata & (8'h01 << `SHG_HC_PMER);
        default:        hctl_r <= hctl_r;
      endcase
    end
  end

  assign page_erase_r = hctl_r[`SHG_HC_PMER];

  // Data byte: written value, or the byte returned by the core bus
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      data_r <= 8'h00;
    end else if (io_wr && io_off == `SHG_OFF_DATA) begin
      data_r <= host_wdata;
    end else if (state_r == shg_bus && mem_done && !cur_wr_r) begin
      data_r <= mem_rdata;
    end
  end

  // Core override registers, three read and three write words
  genvar k;
  generate
    for (k = 0; k < 3; k = k + 1) begin : g_ovr
      always_ff @(posedge sys_clk) begin
        if (reset) begin
          ovr_rd_r[16*k +: 16] <= `SHG_OVR_RST;
          ovr_wr_r[16*k +: 16] <= `SHG_OVR_RST;
        end else if (core_wr && core_addr == (`SHG_COFF_ORD + 3'(k))) begin
          ovr_rd_r[16*k +: 16] <= core_wdata;
        end else if (core_wr && core_addr == (`SHG_COFF_OWR + 3'(k))) begin
          ovr_wr_r[16*k +: 16] <= core_wdata;
        end
      end
    end
  endgenerate

  // Signaling register; each side touches only its own nibble
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      sem_r <= 8'h00;
    end else if (io_wr && io_off == `SHG_OFF_SEM) begin
      sem_r[3:0] <= host_wdata[3:0];
    end else if (core_wr && core_addr == `SHG_COFF_CSEM) begin
      sem_r[7:4] <= core_wdata[7:4];
    end
  end

  // Core control and status; hardware set wins over a same-cycle clear
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      host_error_irq_enable_r <= 1'b0;
      semaphore_irq_enable_r  <= 1'b0;
      host_error_response_field_r   <= `SHG_HOST_ERROR_RESPONSE_FIELD_HOLD;
    end else if (ccst_wr) begin
      host_error_irq_enable_r <= core_wdata[`SHG_CC_HOST_ERROR_IRQ_ENABLE];
      semaphore_irq_enable_r  <= core_wdata[`SHG_CC_SEMAPHORE_IRQ_ENABLE];
      host_error_response_field_r   <= core_wdata[`SHG_CC_HOST_ERROR_RESPONSE_FIELD +: 2];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      host_write_error_flag_r <= 1'b0;
      host_read_error_flag_r <= 1'b0;
      host_semaphore_written_r <= 1'b0;
    end else begin
      host_write_error_flag_r <= (mem_take && req_restr && host_wr) ||
                 (host_write_error_flag_r && !(ccst_wr && core_wdata[`SHG_CC_HOST_WRITE_ERROR_FLAG]));
      host_read_error_flag_r <= (mem_take && req_restr && !host_wr) ||
                 (host_read_error_flag_r && !(ccst_wr && core_wdata[`SHG_CC_HOST_READ_ERROR_FLAG]));
      host_semaphore_written_r <= (io_wr && io_off == `SHG_OFF_SEM) ||
                 (host_semaphore_written_r && !(ccst_wr && core_wdata[`SHG_CC_HOST_SEMAPHORE_WRITTEN]));
    end
  end

  // One interrupt line to the core
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      core_irq_r <= 1'b0;
    end else begin
      core_irq_r <= ((host_write_error_flag_r || host_read_error_flag_r) && host_error_irq_enable_r) || (host_semaphore_written_r && semaphore_irq_enable_r);
    end
  end

  // Core register read, one cycle behind the address
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      core_rdata_r <= 16'h0000;
    end else begin
      case (core_addr)
        3'h0, 3'h1, 3'h2: core_rdata_r <= ovr_rd_r[16*core_addr +: 16];
        3'h3, 3'h4, 3'h5: core_rdata_r <= ovr_wr_r[16*(core_addr - 3'h3) +: 16];
        `SHG_COFF_CCST:   core_rdata_r <= {9'h000, host_semaphore_written_r, host_read_error_flag_r, host_write_error_flag_r,
                                           host_error_response_field_r, semaphore_irq_enable_r, host_error_irq_enable_r};
        default:          core_rdata_r <= {8'h00, sem_r};
      endcase
    end
  end

  // Host transaction sequencer
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      state_r      <= shg_idle;
      host_sync_r  <= `SHG_SYNC_READY;
      host_done_r  <= 1'b0;
      host_rdata_r <= 8'h00;
      mem_req_r    <= 1'b0;
      mem_we_r     <= 1'b0;
      mem_addr_r   <= 21'h000000;
      mem_wdata_r  <= 8'h00;
      cur_addr_r   <= 21'h000000;
      cur_wr_r     <= 1'b0;
    end else begin
      host_done_r <= 1'b0;
      mem_req_r   <= 1'b0;
      case (state_r)
        shg_idle: begin
          if (mem_take) begin
            cur_addr_r  <= req_core;
            cur_wr_r    <= host_wr;
            mem_addr_r  <= req_core;
            mem_we_r    <= host_wr;
            mem_wdata_r <= host_wdata;
            if (!req_restr) begin
              mem_req_r   <= 1'b1;
              host_sync_r <= `SHG_SYNC_LONG;
              state_r     <= shg_bus;
            end else if (host_wr) begin
              host_done_r <= 1'b1;
              host_sync_r <= (host_error_response_field_r == `SHG_HOST_ERROR_RESPONSE_FIELD_ERROR) ? `SHG_SYNC_ERROR : `SHG_SYNC_READY;
            end else if (host_error_response_field_r == `SHG_HOST_ERROR_RESPONSE_FIELD_HOLD) begin
              host_sync_r <= `SHG_SYNC_LONG;
              state_r     <= shg_hold;
            end else begin
              host_done_r  <= 1'b1;
              host_rdata_r <= 8'h00;
              host_sync_r  <= (host_error_response_field_r == `SHG_HOST_ERROR_RESPONSE_FIELD_ERROR) ? `SHG_SYNC_ERROR : `SHG_SYNC_READY;
            end
          end else if (io_take) begin
            host_rdata_r <= io_rd_val;
            host_sync_r  <= `SHG_SYNC_SHORT;
            state_r      <= shg_short;
          end
        end
        shg_short: begin
          host_done_r <= 1'b1;
          host_sync_r <= `SHG_SYNC_READY;
          state_r     <= shg_idle;
        end
        shg_bus: begin
          if (mem_done) begin
            host_done_r  <= 1'b1;
            host_sync_r  <= `SHG_SYNC_READY;
            host_rdata_r <= cur_wr_r ? 8'h00 : mem_rdata;
            state_r      <= shg_idle;
          end
        end
        shg_hold: begin
          // Endless by design: only the read becoming unrestricted or a field change releases it
          if (!hold_restr) begin
            mem_req_r <= 1'b1;
            state_r   <= shg_bus;
          end else if (host_error_response_field_r != `SHG_HOST_ERROR_RESPONSE_FIELD_HOLD) begin
            host_done_r  <= 1'b1;
            host_rdata_r <= 8'h00;
            host_sync_r  <= (host_error_response_field_r == `SHG_HOST_ERROR_RESPONSE_FIELD_ERROR) ? `SHG_SYNC_ERROR : `SHG_SYNC_READY;
            state_r      <= shg_idle;
          end
        end
        default: state_r <= shg_idle;
      endcase
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  sequence short_answer;
    host_sync_r == `SHG_SYNC_SHORT ##1 host_done_r && host_sync_r == `SHG_SYNC_READY;
  endsequence

  AST_SHORT_WAIT: assert property (io_take && !mem_take |=> short_answer)
    else $error("register access not answered with short wait then ready");
  AST_WERR_SET: assert property (mem_take && req_restr && host_wr |=> host_write_error_flag_r)
    else $error("restricted write did not set write error flag");
  AST_RERR_SET: assert property (mem_take && req_restr && !host_wr |=> host_read_error_flag_r)
    else $error("restricted read did not set read error flag");
  AST_NO_BUS: assert property (mem_take && req_restr |=> !mem_req_r)
    else $error("restricted access reached the core bus");
  AST_LOCK_STICKY: assert property (1'b1 |=> (hlp_r & $past(hlp_r)) == $past(hlp_r))
    else $error("lock flag cleared without reset");
  AST_LOCK_FREEZE: assert property (1'b1 |=> ((hrp_r ^ $past(hrp_r)) & $past(hlp_r)) == 32'h0)
    else $error("locked read flag changed");
  AST_HOLD_LONG: assert property (state_r == shg_hold |-> host_sync_r == `SHG_SYNC_LONG)
    else $error("held read not showing long wait");
  AST_SEM_OWN: assert property (io_wr && io_off == `SHG_OFF_SEM |=> $stable(sem_r[7:4]))
    else $error("host write changed core signaling bits");
  AST_SEMW: assert property (io_wr && io_off == `SHG_OFF_SEM |=> host_semaphore_written_r)
    else $error("semaphore written flag not set");
  AST_IRQ: assert property (host_write_error_flag_r && host_error_irq_enable_r |=> core_irq_r)
    else $error("host error interrupt missing");
  AST_BUS_DONE: assert property (state_r == shg_bus && mem_done |=> host_done_r)
    else $error("core bus completion not passed to host");
endmodule

// >>> shg_regs.svh
`ifndef SHG_REGS_SVH
`define SHG_REGS_SVH
// Host I/O register offsets
`define SHG_OFF_ADDR0    4'h0
`define SHG_OFF_ADDR3    4'h3
`define SHG_OFF_DATA     4'h4
`define SHG_OFF_HCTL     4'h5
`define SHG_OFF_HSTAT    4'h6
`define SHG_OFF_PROT_LO  4'h7
`define SHG_OFF_PROT_HI  4'h8
`define SHG_OFF_SEM      4'hC
// Core register offsets
`define SHG_COFF_ORD     3'h0
`define SHG_COFF_OWR     3'h3
`define SHG_COFF_CCST    3'h6
`define SHG_COFF_CSEM    3'h7
// Core control/status bit positions
`define SHG_CC_HOST_ERROR_IRQ_ENABLE   0
`define SHG_CC_SEMAPHORE_IRQ_ENABLE    1
`define SHG_CC_HOST_ERROR_RESPONSE_FIELD     2
`define SHG_CC_HOST_WRITE_ERROR_FLAG     4
`define SHG_CC_HOST_READ_ERROR_FLAG     5
`define SHG_CC_HOST_SEMAPHORE_WRITTEN     6
// Host control bits, reset values, override offset and empty-flash code
`define SHG_HC_PMER      5
`define SHG_HCTL_RST     8'h00
`define SHG_OVR_RST      16'h0000
`define SHG_FINE_OFFSET  6'hE
`define SHG_BOOT_EMPTY   4'hF
// Error response field encodings
`define SHG_HOST_ERROR_RESPONSE_FIELD_HOLD   2'h0
`define SHG_HOST_ERROR_RESPONSE_FIELD_READY  2'h1
`define SHG_HOST_ERROR_RESPONSE_FIELD_ERROR  2'h2
// Sync codes
`define SHG_SYNC_READY   4'h0
`define SHG_SYNC_SHORT   4'h5
`define SHG_SYNC_LONG    4'h6
`define SHG_SYNC_ERROR   4'hA
`endif

// >>> shg_pkg.sv
package shg_pkg;
  typedef enum logic [1:0] {
    shg_idle  = 2'b00,
    shg_short = 2'b01,
    shg_bus   = 2'b11,
    shg_hold  = 2'b10
  } shg_state_type;
endpackage

// >>> shg_mem_model.sv
`timescale 1ns/1ps
module shg_mem_model (
  input  wire logic        sys_clk,
  input  wire logic        reset,
  input  wire logic [3:0]  lat,
  input  wire logic        mem_req,
  input  wire logic        mem_we,
  input  wire logic [20:0] mem_addr,
  input  wire logic [7:0]  mem_wdata,
  output logic      [7:0]  mem_rdata,
  output logic             mem_done
);
  logic [7:0]  store [int];
  logic [3:0]  cnt_r;
  logic        busy_r;
  logic [20:0] addr_r;

  // Read data only means something on the done cycle; it toggles otherwise so stale data fails
  always @(posedge sys_clk) begin
    mem_done <= 1'b0;
    mem_rdata <= ~mem_rdata;
    if (reset) begin
      busy_r <= 1'b0;
      cnt_r <= 4'h0;
      mem_rdata <= 8'hA5;
    end else if (mem_req) begin
      busy_r <= 1'b1;
      cnt_r <= lat;
      addr_r <= mem_addr;
      if (mem_we) begin
        store[int'(mem_addr)] = mem_wdata;
      end
    end else if (busy_r) begin
      if (cnt_r == 4'h0) begin
        busy_r <= 1'b0;
        mem_done <= 1'b1;
        mem_rdata <= store.exists(int'(addr_r)) ? store[int'(addr_r)] : addr_r[7:0];
      end else begin
        cnt_r <= cnt_r - 4'h1;
      end
    end
  end
endmodule

// >>> shg_guard_test.sv
`timescale 1ns/1ps
module shg_guard_test;
  logic        sys_clk, reset, host_req, host_io, host_wr, core_wr, core_irq_r, core_chk;
  logic        host_done_r, mem_req_r, mem_we_r, mem_done, page_erase_r, core_warm_reset;
  logic [31:0] host_addr;
  logic [7:0]  host_wdata, host_rdata_r, mem_wdata_r, mem_rdata, d, s, c;
  logic [3:0]  host_sync_r, boot_block_field, lat;
  logic [2:0]  core_addr;
  logic [15:0] core_wdata, core_rdata_r;
  logic [20:0] mem_addr_r, ia;
  logic [7:0]  b [4];
  logic [12:0] hq [$];
  logic [29:0] mq [$];
  logic [31:0] cq [$];
  logic [12:0] he;
  logic [29:0] me;
  logic [31:0] ce;
  int          errors, check_count, cycles;

  shg_guard uut (.sys_clk(sys_clk), .reset(reset), .host_req(host_req), .host_io(host_io),
    .host_wr(host_wr), .host_addr(host_addr), .host_wdata(host_wdata),
    .host_sync_r(host_sync_r), .host_done_r(host_done_r), .host_rdata_r(host_rdata_r),
    .core_wr(core_wr), .core_addr(core_addr), .core_wdata(core_wdata),
    .core_rdata_r(core_rdata_r), .core_irq_r(core_irq_r),
    .main_block_top_address(21'h010000), .core_warm_reset(core_warm_reset),
    .boot_block_field(boot_block_field), .mem_req_r(mem_req_r), .mem_we_r(mem_we_r),
    .mem_addr_r(mem_addr_r), .mem_wdata_r(mem_wdata_r), .mem_rdata(mem_rdata),
    .mem_done(mem_done), .page_erase_r(page_erase_r));

  shg_mem_model bus (.sys_clk(sys_clk), .reset(reset), .lat(lat), .mem_req(mem_req_r),
    .mem_we(mem_we_r), .mem_addr(mem_addr_r), .mem_wdata(mem_wdata_r),
    .mem_rdata(mem_rdata), .mem_done(mem_done));

  always #20 sys_clk = ~sys_clk;

  task automatic report(input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (e !== g) begin
      errors++;
      $display("ERROR t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  task automatic cmp_host(input logic [11:0] e, input logic [11:0] g);
    report({20'h0, e}, {20'h0, g});
  endtask
  task automatic cmp_mem(input logic [29:0] e, input logic [29:0] g);
    report({2'h0, e}, {2'h0, g});
  endtask
  task automatic cmp_core(input logic [15:0] e, input logic [15:0] g);
    report({16'h0, e}, {16'h0, g});
  endtask

  task automatic wrap_up;
    $display("Checks %0d, mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Scoreboard: every host completion, bus request and core read pops the oldest note
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles > 20000) begin
      errors++;
      wrap_up();
    end
    if (!reset && host_done_r === 1'b1) begin
      he = (hq.size() != 0) ? hq.pop_front() : 13'h1FFF;
      cmp_host({he[11:8], he[12] ? he[7:0] : host_rdata_r}, {host_sync_r, host_rdata_r});
    end
    if (!reset && mem_req_r === 1'b1) begin
      me = (mq.size() != 0) ? mq.pop_front() : 30'h3FFFFFFF;
      cmp_mem({me[29:8], me[29] ? me[7:0] : mem_wdata_r}, {mem_we_r, mem_addr_r, mem_wdata_r});
    end
    if (core_chk === 1'b1) begin
      ce = cq.pop_front();
      cmp_core(ce[15:0], core_rdata_r & ce[31:16]);
    end
  end

  task automatic host_start(input logic io, input logic wr, input logic [31:0] a,
                            input logic [7:0] wd, input logic [3:0] sy, input logic [7:0] r,
                            input logic chk);
    hq.push_back({chk, sy, r});
    @(posedge sys_clk);
    host_req <= 1'b1;
    host_io <= io;
    host_wr <= wr;
    host_addr <= a;
    host_wdata <= wd;
    @(posedge sys_clk);
    host_req <= 1'b0;
  endtask
  task automatic host_wait;
    int n;
    n = 0;
    #1;
    while (host_done_r !== 1'b1 && n < 300) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    if (n == 300) begin
      errors++;
      $display("ERROR t=%0t exp=%h got=%h", $time, 1'b1, host_done_r);
    end
  endtask
  task automatic host_op(input logic io, input logic wr, input logic [31:0] a,
                         input logic [7:0] wd, input logic [3:0] sy, input logic [7:0] r,
                         input logic chk);
    host_start(io, wr, a, wd, sy, r, chk);
    host_wait();
  endtask
  task automatic wr_io(input logic [3:0] off, input logic [7:0] wd);
    host_op(1'b1, 1'b1, {28'h0, off}, wd, 4'h0, 8'h00, 1'b0);
  endtask
  task automatic rd_io(input logic [3:0] off, input logic [7:0] r);
    host_op(1'b1, 1'b0, {28'h0, off}, 8'h00, 4'h0, r, 1'b1);
  endtask
  task automatic core_write(input logic [2:0] a, input logic [15:0] wd);
    @(posedge sys_clk);
    core_wr <= 1'b1;
    core_addr <= a;
    core_wdata <= wd;
    @(posedge sys_clk);
    core_wr <= 1'b0;
  endtask
  task automatic core_read(input logic [2:0] a, input logic [15:0] m, input logic [15:0] e);
    cq.push_back({m, e});
    @(posedge sys_clk);
    core_addr <= a;
    @(posedge sys_clk);
    core_chk <= 1'b1;
    @(posedge sys_clk);
    core_chk <= 1'b0;
  endtask

  initial begin
    void'($urandom(32'h03B1));
    {sys_clk, host_req, host_io, host_wr, core_wr, core_chk, core_warm_reset} = 7'h00;
    {host_addr, host_wdata, core_addr, core_wdata, boot_block_field} = 63'h0;
    {errors, check_count, cycles} = 96'h0;
    lat = 4'h1;
    reset = 1'b1;
    repeat (4) @(posedge sys_clk);
    reset <= 1'b0;
    wr_io(4'h7, 8'h08);
    rd_io(4'h7, 8'h0A);
    wr_io(4'h7, 8'h20);
    rd_io(4'h7, 8'h20);
    wr_io(4'h7, 8'h28);
    rd_io(4'h7, 8'h28);
    wr_io(4'h7, 8'h20);
    for (int i = 0; i < 4; i++) begin
      b[i] = (i == 2) ? 8'h01 : 8'($urandom());
      wr_io(4'(i), b[i]);
    end
    for (int i = 0; i < 4; i++) rd_io(4'(i), b[i]);
    ia = {5'h01, b[1], b[0]} + 21'h010000;
    d = 8'($urandom());
    mq.push_back({1'b1, ia, d});
    host_start(1'b1, 1'b1, 32'h4, d, 4'h0, 8'h00, 1'b0);
    #1 cmp_host({4'h6, 8'h00}, {host_sync_r, 8'h00});
    host_wait();
    lat <= 4'h9;
    mq.push_back({1'b0, ia, 8'h00});
    host_op(1'b1, 1'b0, 32'h4, 8'h00, 4'h0, d, 1'b1);
    lat <= 4'h1;
    host_start(1'b1, 1'b0, 32'h1, 8'h00, 4'h0, b[1], 1'b1);
    #1 cmp_host({4'h5, 8'h00}, {host_sync_r, 8'h00});
    host_wait();
    rd_io(4'h9, 8'h00);
    wr_io(4'h5, 8'h20);
    cmp_core(16'h0001, {15'h0, page_erase_r});
    // Block 0 stays write protected from reset, so every field value answers here
    for (int f = 0; f < 4; f++) begin
      core_write(3'h6, {12'h0, 2'(f), 2'b01});
      host_op(1'b0, 1'b1, 32'h001F0000, 8'($urandom()), (f == 2) ? 4'hA : 4'h0, 8'h00, 1'b0);
    end
    core_read(3'h6, 16'h0010, 16'h0010);
    cmp_core(16'h0001, {15'h0, core_irq_r});
    core_write(3'h6, 16'h0014);
    repeat (3) @(posedge sys_clk);
    cmp_core(16'h0000, {15'h0, core_irq_r});
    wr_io(4'h7, 8'h31);
    for (int f = 1; f < 4; f++) begin
      core_write(3'h6, {12'h0, 2'(f), 2'b00});
      host_op(1'b0, 1'b0, 32'h00020000, 8'h00, (f == 2) ? 4'hA : 4'h0, 8'h00, 1'b1);
    end
    core_read(3'h6, 16'h0020, 16'h0020);
    core_write(3'h6, 16'h0000);
    host_start(1'b0, 1'b0, 32'h00020000, 8'h00, 4'h0, 8'h00, 1'b1);
    repeat (12) @(posedge sys_clk);
    #1 cmp_host({4'h6, 8'h00}, {host_sync_r, 8'h00});
    core_write(3'h6, 16'h0004);
    host_wait();
    core_write(3'h4, 16'h0001);
    host_op(1'b0, 1'b1, 32'h00010010, 8'($urandom()), 4'h0, 8'h00, 1'b0);
    core_read(3'h4, 16'hFFFF, 16'h0001);
    core_write(3'h4, 16'h0000);
    d = 8'($urandom());
    mq.push_back({1'b1, 21'h020010, d});
    host_op(1'b0, 1'b1, 32'h00010010, d, 4'h0, 8'h00, 1'b0);
    mq.push_back({1'b0, 21'h020010, 8'h00});
    host_op(1'b0, 1'b0, 32'h00010010, 8'h00, 4'h0, d, 1'b1);
    core_write(3'h6, 16'h0008);
    for (int k = 0; k < 2; k++) begin
      @(posedge sys_clk);
      core_warm_reset <= (k == 0);
      boot_block_field <= (k == 1) ? 4'hF : 4'h0;
      host_op(1'b0, 1'b0, 32'h00010010, 8'h00, 4'hA, 8'h00, 1'b1);
    end
    core_warm_reset <= 1'b0;
    boot_block_field <= 4'h0;
    wr_io(4'h8, 8'h54);
    wr_io(4'h8, 8'h51);
    wr_io(4'h8, 8'h58);
    rd_io(4'h8, 8'h5C);
    core_write(3'h6, 16'h0072);
    s = 8'($urandom());
    c = 8'($urandom());
    wr_io(4'hC, s);
    rd_io(4'hC, {4'h0, s[3:0]});
    core_write(3'h7, {8'h00, c});
    s = 8'($urandom());
    wr_io(4'hC, s);
    rd_io(4'hC, {c[7:4], s[3:0]});
    core_read(3'h7, 16'hFFFF, {8'h00, c[7:4], s[3:0]});
    core_read(3'h6, 16'h0040, 16'h0040);
    cmp_core(16'h0001, {15'h0, core_irq_r});
    repeat (3) @(posedge sys_clk);
    wrap_up();
  end
endmodule
